// >>> common/fpm_defines.svh
/*
 Front-panel mode control: timing counts, sizes and button bit positions as macros.
 Assumes a 200 MHz mclk_i; included by the design modules.
*/
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH

`define FPM_CLK_MHZ           200
`define FPM_DEBOUNCE_US       10
`define FPM_DEBOUNCE_CYC      (`FPM_DEBOUNCE_US * `FPM_CLK_MHZ)
`define FPM_MAX_FORMULAS      30
`define FPM_OUT_GROUP         12
`define FPM_DISP_LINES        2
`define FPM_DISP_CHARS        20
`define FPM_NUM_BUTTONS       8
`define FPM_MENU_ITEMS        8

// Button bit positions
`define FPM_BTN_START         0
`define FPM_BTN_UP            1
`define FPM_BTN_DOWN          2
`define FPM_BTN_NEXT          3
`define FPM_BTN_CANCEL        4
`define FPM_BTN_MANUAL        5
`define FPM_BTN_TERM          6
`define FPM_BTN_UNLOCK        7

`endif

// >>> common/fpm_pkg.sv
/*
 Front-panel mode control types: operating modes and display pages.
 Assumes fpm_defines.svh is on the include path.
*/
package fpm_pkg;

   typedef enum logic [1:0] {
      FPM_MODE_RUN,
      FPM_MODE_MANUAL,
      FPM_MODE_PROG
   } fpm_mode_t;

   typedef enum logic [3:0] {
      FPM_PG_FORMULA,
      FPM_PG_RUNNING,
      FPM_PG_INPUTS,
      FPM_PG_OUTS_LO,
      FPM_PG_OUTS_HI,
      FPM_PG_LEVEL,
      FPM_PG_MENU,
      FPM_PG_DATECODE,
      FPM_PG_PROG
   } fpm_page_t;

endpackage : fpm_pkg

// >>> hw/fpm_debounce.sv
/*
 Debouncer for the push-buttons: two-flop synchroniser, then a stability
 counter per button. Assumes raw, active-high buttons from panel pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fpm_defines.svh"

module fpm_debounce
   import fpm_pkg::*;
#(
   parameter int N   = `FPM_NUM_BUTTONS,
   parameter int CYC = `FPM_DEBOUNCE_CYC
) (
   input  wire logic         mclk_i,
   input  wire logic         reset_n_i,
   input  wire logic [N-1:0] raw_i,
   output logic      [N-1:0] held_o,
   output logic      [N-1:0] press_o
);

   localparam int CW = $clog2(CYC + 1);

   typedef struct packed {
      logic [N-1:0]        s1;
      logic [N-1:0]        s2;
      logic [N-1:0]        held;
      logic [N-1:0]        press;
      logic [N-1:0][CW-1:0] cnt;
   } fpm_db_t;

   fpm_db_t st_q, st_d;

   always_comb begin
      st_d       = st_q;
      st_d.s1    = raw_i;
      st_d.s2    = st_q.s1;
      st_d.press = '0;
      for (int i = 0; i < N; i++) begin
         if (st_q.s2[i] == st_q.held[i]) begin
            st_d.cnt[i] = '0;
         end else if (st_q.cnt[i] == CW'(CYC - 1)) begin
            st_d.cnt[i]   = '0;
            st_d.held[i]  = st_q.s2[i];
            st_d.press[i] = st_q.s2[i];
         end else begin
            st_d.cnt[i] = st_q.cnt[i] + CW'(1);
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign held_o  = st_q.held;
   assign press_o = st_q.press;

   AST_PRESS_ONCE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (st_q.press != '0) |=> ((st_q.press & $past(st_q.press)) == '0))
      else $error("Press pulse lasted more than one cycle");

endmodule : fpm_debounce
`default_nettype wire

// >>> hw/fpm_panel.sv
/*
 Front-panel mode control for a washer-extractor: run, manual and program
 mode handling of buttons, lights, buzzer and display page selection.
 Assumes the sequencer reports run state and takes start/stop/resume pulses.
 // Function
 // - Start runs formula only with power, door closed
 // - Start held plus up shows inputs
 // - Run light on start, off after coast
 // - Down selects lower formula, 01 wraps highest
 // - Up selects next higher stored formula
 // - Manual held: down upper outputs, up lower
 // - Display is two lines of twenty chars
 // - Cancel+manual+next shows pressure and level
 // - Buzzer on completion, cancel silences it
 // - Signal step pauses until cancel pressed
 // - Signal light follows buzzer
 // - Manual ignored while running; idle enters manual
 // - Terminate cancels formula, starts shutdown, unresumable
 // - Unlock unlocks; held motion stops on release
 // - Manual+start activates item; both shows datecode
 // - Manual mode ignores keyswitch; shown in inputs
 // - Manual: next, cancel dead; lights off
 // - Manual menu down descends, up ascends
 // - Terminate in manual clears outputs, leaves
 // - Program mode by key; start+next/terminate edit
 // - Program: down lower, up higher, next confirms
 // - Program terminate to menu unless locked
 // - Program: cancel, manual, unlock ignored; lights off
*/
`timescale 1ns/10ps
`default_nettype none
`include "fpm_defines.svh"

module fpm_panel
   import fpm_pkg::*;
#(
   parameter int NF       = `FPM_MAX_FORMULAS,
   parameter int DB_CYC   = `FPM_DEBOUNCE_CYC,
   parameter int NMENU    = `FPM_MENU_ITEMS
) (
   input  wire logic         mclk_i,
   input  wire logic         reset_n_i,
   input  wire logic [7:0]   buttons_i,
   input  wire logic         key_prog_i,
   input  wire logic         power_ok_i,
   input  wire logic         door_closed_i,
   input  wire logic [NF-1:0] formula_valid_i,
   input  wire logic         seq_running_i,
   input  wire logic         seq_done_i,
   input  wire logic         seq_coast_done_i,
   input  wire logic         seq_signal_step_i,
   input  wire logic         door_unlocked_i,
   input  wire logic         edit_locked_i,
   output logic              formula_start_o,
   output logic              formula_stop_o,
   output logic              formula_resume_o,
   output logic [4:0]        formula_sel_o,
   output logic              run_light_o,
   output logic              signal_light_o,
   output logic              buzzer_o,
   output logic              door_unlock_o,
   output logic              motion_enable_o,
   output logic [1:0]        mode_o,
   output logic [3:0]        page_o,
   output logic [2:0]        menu_item_o,
   output logic              menu_activate_o,
   output logic              manual_clear_o,
   output logic              step_delete_o,
   output logic              step_insert_o,
   output logic              prog_down_o,
   output logic              prog_up_o,
   output logic              prog_confirm_o,
   output logic              key_sign_o,
   output logic [4:0]        disp_rows_o,
   output logic [4:0]        disp_cols_o
);

   ////////////////////////////////////////////////////////////////////////
   // Button conditioning

   logic [7:0] held, press;

   fpm_debounce #(
      .N   (8),
      .CYC (DB_CYC)
   ) u_db (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .raw_i     (buttons_i),
      .held_o    (held),
      .press_o   (press)
   );

   typedef struct packed {
      logic [1:0] ks;          // Keyswitch synchroniser
      logic [1:0] dr;          // Door-closed synchroniser
      logic [1:0] pw;          // Power synchroniser
      fpm_mode_t  mode;
      fpm_page_t  page;
      logic [4:0] sel;
      logic [2:0] item;
      logic       run_light;
      logic       stopped;     // Operator stopped, wait for unlock
      logic       buzz;
      logic       paused;
      logic       start, stop, resume, act, clr, del, ins, dn, up, cf;
      logic       unlock;
      logic       motion;
   } fpm_st_t;

   fpm_st_t st_q, st_d;

   // Next/previous valid formula with wrap, one generate-free scan
   function automatic logic [4:0] step_sel(input logic [4:0] cur,
                                           input logic [NF-1:0] v,
                                           input logic dir_up);
      logic [4:0] r;
      logic [4:0] k;
      r = cur;
      k = cur;
      for (int i = 0; i < NF; i++) begin
         if (dir_up) begin
            k = (k == 5'(NF - 1)) ? 5'h00 : k + 5'h01;
         end else begin
            k = (k == 5'h00) ? 5'(NF - 1) : k - 5'h01;
         end
         if (v[k] && r == cur) begin
            r = k;
         end
      end
      return r;
   endfunction : step_sel

   ////////////////////////////////////////////////////////////////////////
   // Mode and button decoding

   logic b_st, b_up, b_dn, b_nx, b_cn, b_mn, b_tm, b_ul;
   assign b_st = press[`FPM_BTN_START];
   assign b_up = press[`FPM_BTN_UP];
   assign b_dn = press[`FPM_BTN_DOWN];
   assign b_nx = press[`FPM_BTN_NEXT];
   assign b_cn = press[`FPM_BTN_CANCEL];
   assign b_mn = press[`FPM_BTN_MANUAL];
   assign b_tm = press[`FPM_BTN_TERM];
   assign b_ul = press[`FPM_BTN_UNLOCK];

   logic h_st, h_mn, h_cn, h_nx, h_ul;
   assign h_st = held[`FPM_BTN_START];
   assign h_mn = held[`FPM_BTN_MANUAL];
   assign h_cn = held[`FPM_BTN_CANCEL];
   assign h_nx = held[`FPM_BTN_NEXT];
   assign h_ul = held[`FPM_BTN_UNLOCK];

   always_comb begin
      st_d        = st_q;
      st_d.ks     = {st_q.ks[0], key_prog_i};
      st_d.dr     = {st_q.dr[0], door_closed_i};
      st_d.pw     = {st_q.pw[0], power_ok_i};
      st_d.start  = 1'b0;
      st_d.stop   = 1'b0;
      st_d.resume = 1'b0;
      st_d.act    = 1'b0;
      st_d.clr    = 1'b0;
      st_d.del    = 1'b0;
      st_d.ins    = 1'b0;
      st_d.dn     = 1'b0;
      st_d.up     = 1'b0;
      st_d.cf     = 1'b0;
      st_d.unlock = 1'b0;
      st_d.motion = 1'b0;
      case (st_q.mode)
         FPM_MODE_RUN: begin
            if (st_q.ks[1]) begin
               st_d.mode = FPM_MODE_PROG;
               st_d.page = FPM_PG_PROG;
            end else if (!seq_running_i && !st_q.run_light) begin
               if (b_st && st_q.pw[1] && st_q.dr[1]) begin
                  st_d.start     = 1'b1;
                  st_d.run_light = 1'b1;
                  st_d.page      = FPM_PG_RUNNING;
               end else if (b_up && h_st) begin
                  st_d.page = FPM_PG_INPUTS;
               end else if (b_dn && h_mn) begin
                  st_d.page = FPM_PG_OUTS_HI;
               end else if (b_up && h_mn) begin
                  st_d.page = FPM_PG_OUTS_LO;
               end else if (b_dn) begin
                  st_d.sel  = step_sel(st_q.sel, formula_valid_i, 1'b0);
                  st_d.page = FPM_PG_FORMULA;
               end else if (b_up) begin
                  st_d.sel  = step_sel(st_q.sel, formula_valid_i, 1'b1);
                  st_d.page = FPM_PG_FORMULA;
               end else if (b_mn && st_q.page == FPM_PG_FORMULA && !h_cn) begin
                  st_d.mode = FPM_MODE_MANUAL;
                  st_d.page = FPM_PG_MENU;
                  st_d.item = 3'h0;
               end
            end else if (b_tm && seq_running_i) begin
               st_d.stop    = 1'b1;
               st_d.stopped = 1'b1;
               st_d.paused  = 1'b0;
            end
            // Level view is the one manual use allowed while running
            if ((b_cn || b_mn || b_nx) && h_cn && h_mn && h_nx) begin
               st_d.page = FPM_PG_LEVEL;
            end else if (b_cn) begin
               st_d.buzz = 1'b0;
               if (st_q.paused) begin
                  st_d.paused = 1'b0;
                  st_d.resume = 1'b1;
               end
            end
            if (seq_signal_step_i && !st_q.paused) begin
               st_d.paused = 1'b1;
               st_d.buzz   = 1'b1;
            end
            if (seq_done_i) begin
               st_d.buzz = 1'b1;
            end
            if (st_q.run_light && seq_coast_done_i
                && (!st_q.stopped || door_unlocked_i)) begin
               st_d.run_light = 1'b0;
               st_d.stopped   = 1'b0;
               st_d.page      = FPM_PG_FORMULA;
            end
            st_d.unlock = b_ul;
            st_d.motion = h_ul;
         end
         FPM_MODE_MANUAL: begin
            st_d.buzz   = 1'b0;
            st_d.paused = 1'b0;
            if (b_tm) begin
               st_d.clr  = 1'b1;
               st_d.mode = st_q.ks[1] ? FPM_MODE_PROG : FPM_MODE_RUN;
               st_d.page = st_q.ks[1] ? FPM_PG_PROG : FPM_PG_FORMULA;
            end else if ((b_st && h_mn) || (b_mn && h_st)) begin
               st_d.act  = 1'b1;
               st_d.page = (b_st && b_mn) || (st_q.item == 3'h0)
                           ? FPM_PG_DATECODE : FPM_PG_MENU;
            end else if (b_dn) begin
               st_d.item = (st_q.item == 3'h0) ? 3'(NMENU - 1)
                           : st_q.item - 3'h1;
            end else if (b_up) begin
               st_d.item = (st_q.item == 3'(NMENU - 1)) ? 3'h0
                           : st_q.item + 3'h1;
            end
            st_d.unlock = b_ul;
            st_d.motion = h_ul;
         end
         FPM_MODE_PROG: begin
            st_d.buzz   = 1'b0;
            st_d.paused = 1'b0;
            // A run left lit by a key turn mid-formula goes dark here
            st_d.run_light = 1'b0;
            st_d.stopped   = 1'b0;
            if (!st_q.ks[1]) begin
               st_d.mode = FPM_MODE_RUN;
               st_d.page = FPM_PG_FORMULA;
            end else if (b_nx && h_st) begin
               st_d.del = 1'b1;
            end else if (b_tm && h_st) begin
               st_d.ins = 1'b1;
            end else if (b_tm && !edit_locked_i) begin
               st_d.page = FPM_PG_PROG;
               st_d.item = 3'h0;
            end else if (b_dn) begin
               st_d.dn = 1'b1;
            end else if (b_up) begin
               st_d.up = 1'b1;
            end else if (b_nx) begin
               st_d.cf = 1'b1;
            end
         end
         default: begin
            st_d.mode = FPM_MODE_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= '{mode: FPM_MODE_RUN, page: FPM_PG_FORMULA, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from the state register except the fixed display size

   assign formula_start_o  = st_q.start;
   assign formula_stop_o   = st_q.stop;
   assign formula_resume_o = st_q.resume;
   assign formula_sel_o    = st_q.sel;
   assign run_light_o      = st_q.run_light;
   assign signal_light_o   = st_q.buzz;
   assign buzzer_o         = st_q.buzz;
   assign door_unlock_o    = st_q.unlock;
   assign motion_enable_o  = st_q.motion;
   assign mode_o           = st_q.mode;
   assign page_o           = st_q.page;
   assign menu_item_o      = st_q.item;
   assign menu_activate_o  = st_q.act;
   assign manual_clear_o   = st_q.clr;
   assign step_delete_o    = st_q.del;
   assign step_insert_o    = st_q.ins;
   assign prog_down_o      = st_q.dn;
   assign prog_up_o        = st_q.up;
   assign prog_confirm_o   = st_q.cf;
   assign key_sign_o       = st_q.ks[1];
   assign disp_rows_o      = 5'(`FPM_DISP_LINES);
   assign disp_cols_o      = 5'(`FPM_DISP_CHARS);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_idle_start;
      st_q.mode == FPM_MODE_RUN && !st_q.ks[1] && !seq_running_i
      && !st_q.run_light && b_st;
   endsequence

   AST_START_GATED: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      s_idle_start |=> (formula_start_o == ($past(st_q.pw[1]) && $past(st_q.dr[1]))))
      else $error("Start not gated by power and door");
   AST_RUN_LIGHT_ON: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      formula_start_o |-> run_light_o)
      else $error("Run light not lit at start");
   AST_SIG_BUZZ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      signal_light_o == buzzer_o)
      else $error("Signal light differs from buzzer");
   AST_DONE_BUZZ: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (st_q.mode == FPM_MODE_RUN && !st_q.ks[1] && seq_done_i) |=> buzzer_o)
      else $error("Buzzer silent after completion");
   AST_TERM_STOP: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (st_q.mode == FPM_MODE_RUN && !st_q.ks[1] && seq_running_i && b_tm)
      |=> formula_stop_o ##1 !formula_stop_o)
      else $error("Terminate did not stop once");
   AST_MANUAL_QUIET: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (st_q.mode == FPM_MODE_MANUAL) |=> !buzzer_o && !formula_resume_o)
      else $error("Manual mode drove signal light");
   AST_MANUAL_EXIT: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (st_q.mode == FPM_MODE_MANUAL && b_tm) |=> manual_clear_o
      && mode_o == ($past(st_q.ks[1]) ? 2'(FPM_MODE_PROG) : 2'(FPM_MODE_RUN)))
      else $error("Manual exit wrong");
   AST_PROG_KEY: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (st_q.mode == FPM_MODE_PROG) |-> $past(st_q.ks[1]))
      else $error("Program mode without key");
   AST_PROG_QUIET: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (st_q.mode == FPM_MODE_PROG) |=> !door_unlock_o && !buzzer_o && !run_light_o)
      else $error("Program mode acted on ignored button");
   AST_CANCEL_RESUME: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (st_q.mode == FPM_MODE_RUN && st_q.paused && b_cn && !h_mn) |=> formula_resume_o)
      else $error("Cancel did not resume paused formula");

endmodule : fpm_panel
`default_nettype wire

// >>> test/fpm_operator_model.sv
/*
 Operator model: panel push-buttons and the run/program keyswitch.
 Assumes the bench calls push and turn_key; buttons are raw, active high.
*/
`timescale 1ns/10ps
`default_nettype none

module fpm_operator_model (
   input  wire logic       mclk_i,
   output logic      [7:0] buttons_o,
   output logic            key_prog_o
);
   // Each phase outlasts sync plus debounce (DB_CYC = 4 in the bench)
   localparam int HOLD = 12;

   initial begin
      buttons_o  = 8'h00;
      key_prog_o = 1'b0;
   end

   // Held buttons settle first so the tap sees them already held
   task automatic push(input logic [7:0] held, input logic [7:0] tap);
      if (held != 8'h00) begin
         @(posedge mclk_i) buttons_o <= held;
         repeat (HOLD) @(posedge mclk_i);
      end
      @(posedge mclk_i) buttons_o <= held | tap;
      repeat (HOLD) @(posedge mclk_i);
      @(posedge mclk_i) buttons_o <= 8'h00;
      repeat (HOLD) @(posedge mclk_i);
   endtask : push

   // Leaves the buttons at one level for a full phase
   task automatic hold(input logic [7:0] level);
      @(posedge mclk_i) buttons_o <= level;
      repeat (HOLD) @(posedge mclk_i);
   endtask : hold

   task automatic turn_key(input logic prog);
      @(posedge mclk_i) key_prog_o <= prog;
      repeat (HOLD) @(posedge mclk_i);
   endtask : turn_key

endmodule : fpm_operator_model
`default_nettype wire

// >>> test/fpm_panel_test.sv
/*
 Self-checking bench for fpm_panel: selection, start, run, manual, program.
 Assumes fpm_operator_model drives buttons and keyswitch; DB_CYC set to 4.
*/
`timescale 1ns/10ps
`default_nettype none

module fpm_panel_test
   import fpm_pkg::*;
;
   localparam logic [7:0] B_ST = 8'h01, B_UP = 8'h02, B_DN = 8'h04, B_NX = 8'h08;
   localparam logic [7:0] B_CN = 8'h10, B_MA = 8'h20, B_TM = 8'h40, B_UL = 8'h80;
   // Pulse bits: start stop resume unlock down up confirm act clear del ins
   localparam logic [15:0] P_ST = 16'h0001, P_SP = 16'h0002, P_RS = 16'h0004;
   localparam logic [15:0] P_UL = 16'h0008, P_DN = 16'h0010, P_UP = 16'h0020;
   localparam logic [15:0] P_CF = 16'h0040, P_AC = 16'h0080, P_CL = 16'h0100;
   localparam logic [15:0] P_DE = 16'h0200, P_IN = 16'h0400;

   logic mclk_i, reset_n_i, power_ok_i, door_closed_i, seq_running_i, seq_done_i;
   logic seq_coast_done_i, seq_signal_step_i, door_unlocked_i, edit_locked_i;
   logic [7:0] buttons_i;
   logic key_prog_i, clr;
   logic [29:0] formula_valid_i;
   wire logic [10:0] pulses;
   logic [15:0] seen;
   logic [4:0] formula_sel_o, disp_rows_o, disp_cols_o;
   logic [1:0] mode_o;
   logic [3:0] page_o;
   logic [2:0] menu_item_o;
   logic run_light_o, signal_light_o, buzzer_o, motion_enable_o, key_sign_o;
   int bad_count, compares;

   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   fpm_operator_model u_op (.mclk_i(mclk_i), .buttons_o(buttons_i), .key_prog_o(key_prog_i));

   fpm_panel #(.DB_CYC(4)) DUT (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .buttons_i(buttons_i),
      .key_prog_i(key_prog_i), .power_ok_i(power_ok_i), .door_closed_i(door_closed_i),
      .formula_valid_i(formula_valid_i), .seq_running_i(seq_running_i),
      .seq_done_i(seq_done_i), .seq_coast_done_i(seq_coast_done_i),
      .seq_signal_step_i(seq_signal_step_i), .door_unlocked_i(door_unlocked_i),
      .edit_locked_i(edit_locked_i), .formula_start_o(pulses[0]),
      .formula_stop_o(pulses[1]), .formula_resume_o(pulses[2]),
      .formula_sel_o(formula_sel_o), .run_light_o(run_light_o),
      .signal_light_o(signal_light_o), .buzzer_o(buzzer_o), .door_unlock_o(pulses[3]),
      .motion_enable_o(motion_enable_o), .mode_o(mode_o), .page_o(page_o),
      .menu_item_o(menu_item_o), .menu_activate_o(pulses[7]),
      .manual_clear_o(pulses[8]), .step_delete_o(pulses[9]), .step_insert_o(pulses[10]),
      .prog_down_o(pulses[4]), .prog_up_o(pulses[5]), .prog_confirm_o(pulses[6]),
      .key_sign_o(key_sign_o), .disp_rows_o(disp_rows_o), .disp_cols_o(disp_cols_o)
   );

   // Sticky record so one-cycle pulses are never missed
   always @(posedge mclk_i) begin
      if (clr) seen <= 16'h0000;
      else seen <= seen | {5'h00, pulses};
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic act(input logic [7:0] held, input logic [7:0] tap, input logic [15:0] exp);
      @(posedge mclk_i) clr <= 1'b1;
      @(posedge mclk_i) clr <= 1'b0;
      u_op.push(held, tap);
      check(seen, exp);
   endtask : act

   // One-cycle sequencer event: completion when done is set, else signal step
   task automatic pulse_in(input logic done);
      @(posedge mclk_i) begin
         if (done) seq_done_i <= 1'b1;
         else seq_signal_step_i <= 1'b1;
      end
      @(posedge mclk_i) {seq_done_i, seq_signal_step_i} <= 2'b00;
      repeat (3) @(posedge mclk_i);
   endtask : pulse_in

   ////////////////////////////////////////////////////////////////////////
   task automatic t_select();
      check(16'({disp_rows_o, disp_cols_o}), 16'({5'd2, 5'd20}));
      check({5'h00, mode_o, page_o, formula_sel_o}, 16'h0000);
      act(8'h00, B_UP, 16'h0000);
      check(16'(formula_sel_o), 16'h0002);
      act(8'h00, B_DN, 16'h0000);
      check(16'(formula_sel_o), 16'h0000);
      act(8'h00, B_DN, 16'h0000);
      check(16'(formula_sel_o), 16'h0005);
   endtask : t_select

   task automatic t_manual();
      act(8'h00, B_MA, 16'h0000);
      check(16'(mode_o), 16'(FPM_MODE_MANUAL));
      act(8'h00, B_UP, 16'h0000);
      check(16'(menu_item_o), 16'h0001);
      act(8'h00, B_DN, 16'h0000);
      check(16'(menu_item_o), 16'h0000);
      act(8'h00, B_NX, 16'h0000);
      act(8'h00, B_CN, 16'h0000);
      check(16'({run_light_o, signal_light_o}), 16'h0000);
      act(B_MA, B_ST, P_AC);
      u_op.turn_key(1'b1);
      check(16'({key_sign_o, mode_o}), {13'h0000, 1'b1, FPM_MODE_MANUAL});
      u_op.turn_key(1'b0);
      act(8'h00, B_TM, P_CL);
      check(16'(mode_o), 16'(FPM_MODE_RUN));
   endtask : t_manual

   task automatic t_run();
      act(B_CN | B_MA, B_NX, 16'h0000);
      check(16'(page_o), 16'(FPM_PG_LEVEL));
      act(B_MA, B_DN, 16'h0000);
      check(16'(page_o), 16'(FPM_PG_OUTS_HI));
      act(B_MA, B_UP, 16'h0000);
      check(16'(page_o), 16'(FPM_PG_OUTS_LO));
      act(B_ST, B_UP, 16'h0000);
      check(16'(page_o), 16'(FPM_PG_INPUTS));
      check(16'(run_light_o), 16'h0000);
      door_closed_i <= 1'b1;
      act(8'h00, B_ST, P_ST);
      check(16'({run_light_o, page_o}), {11'h000, 1'b1, FPM_PG_RUNNING});
      seq_running_i <= 1'b1;
      act(8'h00, B_MA, 16'h0000);
      check(16'(mode_o), 16'(FPM_MODE_RUN));
      act(8'h00, B_TM, P_SP);
      seq_running_i <= 1'b0;
      seq_coast_done_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      check(16'(run_light_o), 16'h0001);
      door_unlocked_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      check(16'(run_light_o), 16'h0000);
      seq_coast_done_i <= 1'b0;
      act(8'h00, B_UL, P_UL);
      u_op.hold(B_UL);
      check(16'(motion_enable_o), 16'h0001);
      u_op.hold(8'h00);
      check(16'(motion_enable_o), 16'h0000);
      pulse_in(1'b1);
      check(16'({buzzer_o, signal_light_o}), 16'h0003);
      act(8'h00, B_CN, 16'h0000);
      check(16'({buzzer_o, signal_light_o}), 16'h0000);
      pulse_in(1'b0);
      check(16'(buzzer_o), 16'h0001);
      act(8'h00, B_CN, P_RS);
      check(16'(buzzer_o), 16'h0000);
   endtask : t_run

   task automatic t_prog();
      act(8'h00, B_MA, 16'h0000);
      act(8'h00, B_UP, 16'h0000);
      u_op.turn_key(1'b1);
      check(16'(mode_o), 16'(FPM_MODE_MANUAL));
      act(8'h00, B_TM, P_CL);
      check(16'(mode_o), 16'(FPM_MODE_PROG));
      act(8'h00, B_DN, P_DN);
      act(8'h00, B_UP, P_UP);
      act(8'h00, B_NX, P_CF);
      act(B_ST, B_NX, P_DE);
      act(B_ST, B_TM, P_IN);
      act(8'h00, B_CN, 16'h0000);
      act(8'h00, B_MA, 16'h0000);
      act(8'h00, B_UL, 16'h0000);
      check(16'({run_light_o, signal_light_o, mode_o}), 16'(FPM_MODE_PROG));
      edit_locked_i <= 1'b1;
      act(8'h00, B_TM, 16'h0000);
      check(16'(menu_item_o), 16'h0001);
      edit_locked_i <= 1'b0;
      act(8'h00, B_TM, 16'h0000);
      check(16'(menu_item_o), 16'h0000);
   endtask : t_prog

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   initial begin
      bad_count = 0;
      compares = 0;
      clr = 1'b0;
      reset_n_i = 1'b0;
      power_ok_i = 1'b1;
      door_closed_i = 1'b0;
      formula_valid_i = 30'h0000_0025;
      {seq_running_i, seq_done_i, seq_coast_done_i, seq_signal_step_i} = 4'h0;
      {door_unlocked_i, edit_locked_i} = 2'h0;
      repeat (2) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      t_select();
      t_manual();
      t_run();
      t_prog();
      tally_and_finish();
   end

endmodule : fpm_panel_test
`default_nettype wire
